// File: hdl/jlsr_regs.sv
/*
  Lane status register bank for lanes five and six of the link receiver,
  with a link page selector and an error count threshold, on classic Wishbone.
  Assumes lane state inputs come from receiver logic on the same clock, so
  they reach the flag logic without synchronisers, and that the bus master
  holds each request until ack or err answers it; a second request is taken
  only after the answer has dropped.
*/
// How it works
// - Bit 7: disparity count at or above threshold
// - Bit 6: invalid code count reached threshold
// - Bit 5: stray control count reached threshold
// - Bit 4: lane deskew achieved
// - Bit 3: initial lane sync achieved
// - Bit 2: configuration checksum correct
// - Bit 1: frame sync held
// - Bit 0: code group sync achieved
// - Fields follow link chosen by page selector
`timescale 1ns/10ps
module jlsr_regs #(
  parameter int unsigned NUM_LINKS = 2
) (
  // Clock and reset
  input  wire logic                       clk_i,
  input  wire logic                       rst_i,
  // Wishbone slave
  input  wire logic                       cyc_i,
  input  wire logic                       stb_i,
  input  wire logic                       we_i,
  input  wire logic [3:0]                 sel_i,
  input  wire logic [11:0]                adr_i,
  input  wire logic [31:0]                dat_i,
  output logic [31:0]                     dat_o,
  output logic                            ack_o,
  output logic                            err_o,
  // Receiver state, per link
  input  wire jlsr_pkg::jlsr_lane_state_t lane_five_i [NUM_LINKS],
  input  wire jlsr_pkg::jlsr_lane_state_t lane_six_i  [NUM_LINKS],
  // Status bytes of the selected link
  output logic [7:0]                      lane_five_link_status_o,
  output logic [7:0]                      lane_six_link_status_o,
  output logic                            link_page_o
);

  // The page selector is one bit wide, so exactly two links fit
  if (NUM_LINKS != 2) begin : g_link_count_check
    $error("jlsr_regs serves exactly two links");
  end

  // Flag positions must fit the eight-bit status byte
  if (jlsr_pkg::DISPARITY_BIT > 7) begin : g_flag_pos_check
    $error("jlsr_regs status fields exceed eight bits");
  end

  // Registers that a bus address can reach
  typedef enum {
    JLSR_SEL_NONE,
    JLSR_SEL_PAGE,
    JLSR_SEL_THRESH,
    JLSR_SEL_LANE_FIVE,
    JLSR_SEL_LANE_SIX
  } jlsr_reg_sel_t;

  // Full byte address compare; aliases would hide stray software accesses
  function automatic jlsr_reg_sel_t decode_reg(input logic [11:0] adr);
    jlsr_reg_sel_t hit;
    hit = JLSR_SEL_NONE;
    unique case (adr)
      jlsr_pkg::LINK_PAGE_OFS: begin
        hit = JLSR_SEL_PAGE;
      end
      jlsr_pkg::ERR_THRESH_OFS: begin
        hit = JLSR_SEL_THRESH;
      end
      jlsr_pkg::LANE_FIVE_STATUS_OFS: begin
        hit = JLSR_SEL_LANE_FIVE;
      end
      jlsr_pkg::LANE_SIX_STATUS_OFS: begin
        hit = JLSR_SEL_LANE_SIX;
      end
      default: begin
        hit = JLSR_SEL_NONE;
      end
    endcase
    return hit;
  endfunction

  // The 8-bit registers sit in byte lane zero
  function automatic logic low_byte_write(input jlsr_pkg::jlsr_wb_req_t r);
    return r.we && r.sel[0];
  endfunction

  // Upper bits of every register read as zero
  function automatic logic [31:0] widen_byte(input logic [7:0] b);
    return {24'h00_0000, b};
  endfunction

  // Lane state of the link that the page selector names
  function automatic jlsr_pkg::jlsr_lane_state_t pick_link(
    input jlsr_pkg::jlsr_lane_state_t lanes [NUM_LINKS],
    input logic                       page
  );
    return lanes[page];
  endfunction

  // Word returned for a decoded register; unmapped reads return zero
  function automatic logic [31:0] read_word(
    input jlsr_reg_sel_t hit,
    input logic          page,
    input logic [7:0]    thresh,
    input logic [7:0]    five,
    input logic [7:0]    six
  );
    logic [31:0] word;
    word = 32'h0000_0000;
    unique case (hit)
      JLSR_SEL_PAGE: begin
        word = widen_byte({7'h00, page});
      end
      JLSR_SEL_THRESH: begin
        word = widen_byte(thresh);
      end
      JLSR_SEL_LANE_FIVE: begin
        word = widen_byte(five);
      end
      JLSR_SEL_LANE_SIX: begin
        word = widen_byte(six);
      end
      JLSR_SEL_NONE: begin
        word = 32'h0000_0000;
      end
    endcase
    return word;
  endfunction

  // Bus request and its decode
  jlsr_pkg::jlsr_wb_req_t          req;
  logic                            access;
  logic                            wr_low;
  jlsr_reg_sel_t                   reg_sel;

  // Control state
  logic                            page_reg;
  logic                            page_next;
  logic [7:0]                      thresh_reg;
  logic [7:0]                      thresh_next;

  // Status state and the flags that feed it
  logic [7:0]                      five_reg;
  logic [7:0]                      five_next;
  logic [7:0]                      six_reg;
  logic [7:0]                      six_next;
  logic [7:0]                      five_flags;
  logic [7:0]                      six_flags;
  jlsr_pkg::jlsr_lane_state_t      five_sel;
  jlsr_pkg::jlsr_lane_state_t      six_sel;

  // Answer state
  logic                            ack_reg;
  logic                            ack_next;
  logic                            err_reg;
  logic                            err_next;
  logic [31:0]                     rdat_reg;
  logic [31:0]                     rdat_next;

  assign req = '{cyc: cyc_i, stb: stb_i, we: we_i, sel: sel_i, adr: adr_i, dat: dat_i};

  // Page selects which link feeds the flags
  assign five_sel = pick_link(lane_five_i, page_reg);
  assign six_sel  = pick_link(lane_six_i, page_reg);

  // One fold per lane; both share the threshold
  jlsr_lane_flags u_five (
    .state_i  (five_sel),
    .thresh_i (thresh_reg),
    .flags_o  (five_flags)
  );

  jlsr_lane_flags u_six (
    .state_i  (six_sel),
    .thresh_i (thresh_reg),
    .flags_o  (six_flags)
  );

  // New request only when no answer is outstanding, so ack is one cycle
  assign access  = req.cyc && req.stb && !ack_reg && !err_reg;
  assign reg_sel = decode_reg(req.adr);
  assign wr_low  = low_byte_write(req);

  // Control group: page selector and error count threshold
  always_comb begin
    page_next   = page_reg;
    thresh_next = thresh_reg;
    if (access && wr_low) begin
      unique case (reg_sel)
        JLSR_SEL_PAGE: begin
          page_next = req.dat[0];
        end
        JLSR_SEL_THRESH: begin
          thresh_next = req.dat[7:0];
        end
        // Status bytes belong to the receiver; such writes are acked and dropped
        JLSR_SEL_LANE_FIVE, JLSR_SEL_LANE_SIX: begin
          page_next   = page_reg;
          thresh_next = thresh_reg;
        end
        JLSR_SEL_NONE: begin
          page_next   = page_reg;
          thresh_next = thresh_reg;
        end
      endcase
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      page_reg   <= jlsr_pkg::PAGE_RESET;
      thresh_reg <= jlsr_pkg::THRESH_RESET;
    end else begin
      page_reg   <= page_next;
      thresh_reg <= thresh_next;
    end
  end

  // Lane five status: sampled every cycle, one edge behind the lane state
  always_comb begin
    five_next = five_flags;
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      five_reg <= jlsr_pkg::STATUS_RESET;
    end else begin
      five_reg <= five_next;
    end
  end

  // Lane six status: same timing as lane five
  always_comb begin
    six_next = six_flags;
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      six_reg <= jlsr_pkg::STATUS_RESET;
    end else begin
      six_reg <= six_next;
    end
  end

  // Handshake group: one-cycle ack for mapped, err for unmapped addresses
  always_comb begin
    ack_next = 1'b0;
    err_next = 1'b0;
    if (access) begin
      unique case (reg_sel)
        JLSR_SEL_PAGE, JLSR_SEL_THRESH, JLSR_SEL_LANE_FIVE, JLSR_SEL_LANE_SIX: begin
          ack_next = 1'b1;
        end
        // Refused rather than silently acked, so software sees the stray access
        JLSR_SEL_NONE: begin
          err_next = 1'b1;
        end
      endcase
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_reg <= 1'b0;
      err_reg <= 1'b0;
    end else begin
      ack_reg <= ack_next;
      err_reg <= err_next;
    end
  end

  // Read data group: loaded on every taken access, held until the next
  always_comb begin
    rdat_next = rdat_reg;
    if (access) begin
      rdat_next = read_word(reg_sel, page_reg, thresh_reg, five_reg, six_reg);
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rdat_reg <= 32'h0000_0000;
    end else begin
      rdat_reg <= rdat_next;
    end
  end

  // Every output comes straight from a flip-flop
  assign dat_o                   = rdat_reg;
  assign ack_o                   = ack_reg;
  assign err_o                   = err_reg;
  assign lane_five_link_status_o = five_reg;
  assign lane_six_link_status_o  = six_reg;
  assign link_page_o             = page_reg;

endmodule // jlsr_regs

// File: hdl/jlsr_pkg.sv
/*
  Package for the lane status register bank: offsets, field positions,
  reset values and the struct that carries one lane's raw receiver state.
  Assumes a 12-bit register address space reached over classic Wishbone.
*/
package jlsr_pkg;

  localparam int unsigned ADDR_W       = 12;
  localparam int unsigned DATA_W       = 32;
  localparam int unsigned CNT_W        = 8;

  // Register offsets (byte addresses)
  localparam logic [11:0] LINK_PAGE_OFS        = 12'h300;
  localparam logic [11:0] ERR_THRESH_OFS       = 12'h304;
  localparam logic [11:0] LANE_FIVE_STATUS_OFS = 12'h4b5;
  localparam logic [11:0] LANE_SIX_STATUS_OFS  = 12'h4b6;

  // Status field positions
  localparam int unsigned DISPARITY_BIT   = 7;
  localparam int unsigned INVALID_BIT     = 6;
  localparam int unsigned STRAY_K_BIT     = 5;
  localparam int unsigned ALIGN_BIT       = 4;
  localparam int unsigned INIT_SYNC_BIT   = 3;
  localparam int unsigned CHECKSUM_BIT    = 2;
  localparam int unsigned FRAME_SYNC_BIT  = 1;
  localparam int unsigned CODE_GROUP_BIT  = 0;

  // Reset values
  localparam logic [7:0]  STATUS_RESET     = 8'h00;
  localparam logic [7:0]  THRESH_RESET     = 8'h00;
  localparam logic        PAGE_RESET       = 1'b0;

  // Raw state of one lane on one link, as the receiver reports it
  typedef struct packed {
    logic [7:0] disparity_cnt;
    logic [7:0] invalid_cnt;
    logic [7:0] stray_k_cnt;
    logic       deskew_ok;
    logic       init_sync_ok;
    logic       checksum_ok;
    logic       frame_sync_ok;
    logic       code_group_ok;
  } jlsr_lane_state_t;

  // Wishbone request as sampled by the slave
  typedef struct packed {
    logic        cyc;
    logic        stb;
    logic        we;
    logic [3:0]  sel;
    logic [11:0] adr;
    logic [31:0] dat;
  } jlsr_wb_req_t;

endpackage

// File: hdl/jlsr_lane_flags.sv
/*
  Folds one lane's raw receiver state into its eight-bit status byte.
  Assumes the counts and sync levels are already in the register clock domain.
*/
`timescale 1ns/10ps
module jlsr_lane_flags (
  // Raw lane state
  input  wire jlsr_pkg::jlsr_lane_state_t state_i,
  // Threshold
  input  wire logic [7:0]                 thresh_i,
  // Status byte
  output logic [7:0]                      flags_o
);

  function automatic logic at_thresh(input logic [7:0] cnt, input logic [7:0] th);
    at_thresh = (cnt >= th);
  endfunction

  always_comb begin
    flags_o = jlsr_pkg::STATUS_RESET;
    flags_o[jlsr_pkg::DISPARITY_BIT]  = at_thresh(state_i.disparity_cnt, thresh_i);
    flags_o[jlsr_pkg::INVALID_BIT]    = at_thresh(state_i.invalid_cnt, thresh_i);
    flags_o[jlsr_pkg::STRAY_K_BIT]    = at_thresh(state_i.stray_k_cnt, thresh_i);
    flags_o[jlsr_pkg::ALIGN_BIT]      = state_i.deskew_ok;
    flags_o[jlsr_pkg::INIT_SYNC_BIT]  = state_i.init_sync_ok;
    flags_o[jlsr_pkg::CHECKSUM_BIT]   = state_i.checksum_ok;
    flags_o[jlsr_pkg::FRAME_SYNC_BIT] = state_i.frame_sync_ok;
    flags_o[jlsr_pkg::CODE_GROUP_BIT] = state_i.code_group_ok;
  end

endmodule // jlsr_lane_flags

// File: verification/jlsr_regs_asserts.sv
/* Checker for jlsr_regs, bound to it; sees its ports only. Assumes one clock, reset active high. */
`timescale 1ns/10ps
module jlsr_regs_asserts #(parameter int unsigned NUM_LINKS = 2) (
  input wire logic                       clk_i, rst_i, cyc_i, stb_i, we_i, ack_o, err_o, link_page_o,
  input wire logic [3:0]                 sel_i,
  input wire logic [11:0]                adr_i,
  input wire logic [31:0]                dat_i, dat_o,
  input wire logic [7:0]                 lane_five_link_status_o, lane_six_link_status_o,
  input wire jlsr_pkg::jlsr_lane_state_t lane_five_i [NUM_LINKS], lane_six_i [NUM_LINKS]
);
  logic [7:0] thr, e5, e6;
  logic [1:0] up;
  wire take = cyc_i && stb_i && !ack_o && !err_o;
  wire mapped = adr_i inside {12'h300, 12'h304, 12'h4b5, 12'h4b6};
  function automatic logic [7:0] fl(jlsr_pkg::jlsr_lane_state_t s, logic [7:0] t);
    return {s.disparity_cnt >= t, s.invalid_cnt >= t, s.stray_k_cnt >= t, s[4:0]};
  endfunction
  // Shadow threshold; the status bytes lag inputs by one edge
  always_ff @(posedge clk_i) begin
    up <= rst_i ? 2'b00 : {up[0], 1'b1};
    thr <= rst_i ? 8'h00 : (take && we_i && sel_i[0] && adr_i == 12'h304) ? dat_i[7:0] : thr;
    e5 <= fl(lane_five_i[link_page_o], thr);
    e6 <= fl(lane_six_i[link_page_o], thr);
  end
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  sequence s_take; take; endsequence
  property p_cnt5; up[1] |-> lane_five_link_status_o[7:5] == e5[7:5]; endproperty
  a_cnt5: assert property (p_cnt5) else $error("lane five count flags wrong");
  property p_cnt6; up[1] |-> lane_six_link_status_o[7:5] == e6[7:5]; endproperty
  a_cnt6: assert property (p_cnt6) else $error("lane six count flags wrong");
  property p_sync5; up[1] |-> lane_five_link_status_o[4:0] == e5[4:0]; endproperty
  a_sync5: assert property (p_sync5) else $error("lane five sync flags wrong");
  property p_sync6; up[1] |-> lane_six_link_status_o[4:0] == e6[4:0]; endproperty
  a_sync6: assert property (p_sync6) else $error("lane six sync flags wrong");
  property p_page; s_take ##0 (we_i && sel_i[0] && adr_i == 12'h300) |=> link_page_o == $past(dat_i[0]); endproperty
  a_page: assert property (p_page) else $error("page select not written");
  property p_ack; s_take ##0 mapped |=> ack_o && !err_o ##1 !ack_o; endproperty
  a_ack: assert property (p_ack) else $error("mapped access not acked once");
  property p_err; s_take ##0 !mapped |=> err_o && !ack_o && $stable(link_page_o); endproperty
  a_err: assert property (p_err) else $error("unmapped access not refused");
  property p_rd; s_take ##0 (!we_i && adr_i == 12'h4b6) |=> dat_o == {24'h000000, $past(lane_six_link_status_o)}; endproperty
  a_rd: assert property (p_rd) else $error("lane six read data wrong");
endmodule // jlsr_regs_asserts
bind jlsr_regs jlsr_regs_asserts #(.NUM_LINKS(NUM_LINKS)) jlsr_regs_asserts_inst (.*);

// File: verification/jlsr_tx_model.sv
/* Far-end model: lane state per link as the receiver reports it. Assumes the bench sets targets. */
`timescale 1ns/10ps
module jlsr_tx_model (
  input  wire logic                       clk_i,
  input  wire jlsr_pkg::jlsr_lane_state_t tgt5_i [2], tgt6_i [2],
  output jlsr_pkg::jlsr_lane_state_t      lane_five_o [2], lane_six_o [2]
);
  // Moves only on the register clock, as the receiver's state would
  always_ff @(posedge clk_i) begin
    lane_five_o <= tgt5_i;
    lane_six_o <= tgt6_i;
  end
endmodule // jlsr_tx_model

// File: verification/tb_jlsr_regs.sv
/* Bench for jlsr_regs: Wishbone accesses against expected status bytes. Assumes the far-end model feeds lanes. */
`timescale 1ns/10ps
module tb_jlsr_regs;
  logic                       clk_i, rst_i, cyc_i, stb_i, we_i, ack_o, err_o, link_page_o, er;
  logic [3:0]                 sel_i;
  logic [11:0]                adr_i;
  logic [31:0]                dat_i, dat_o, rd;
  logic [7:0]                 lane_five_link_status_o, lane_six_link_status_o;
  jlsr_pkg::jlsr_lane_state_t lane_five_i [2], lane_six_i [2], t5 [2], t6 [2];
  int                         err_count = 0, n_checks = 0;
  jlsr_regs jlsr_regs_inst (.*);
  jlsr_tx_model jlsr_tx_model_inst (.clk_i, .tgt5_i(t5), .tgt6_i(t6), .lane_five_o(lane_five_i), .lane_six_o(lane_six_i));
  initial begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end
  task automatic chk(logic [31:0] got, logic [31:0] exp, string nm);
    n_checks++;
    if (got !== exp) begin
      err_count++;
      $display("mismatch %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic give_verdict;
    $display("checks %0d errors %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  // Holds the request until ack or err; only the watchdog bounds the wait
  task automatic wb(logic w, logic [11:0] a, logic [31:0] d);
    @(posedge clk_i);
    {cyc_i, stb_i, we_i, sel_i, adr_i, dat_i} <= {2'b11, w, 4'h1, a, d};
    do begin
      @(posedge clk_i);
    end while (ack_o !== 1'b1 && err_o !== 1'b1);
    rd = dat_o;
    er = err_o;
    {cyc_i, stb_i} <= 2'b00;
  endtask
  task automatic rdchk(logic [11:0] a, logic [31:0] exp, string nm);
    wb(1'b0, a, 32'h0);
    chk(rd, exp, nm);
  endtask
  initial begin
    {cyc_i, stb_i, we_i, rst_i, sel_i, adr_i, dat_i} = {4'b0001, 4'h1, 12'h000, 32'h0};
    t5 = '{default: '0};
    t6 = '{default: '0};
    repeat (4) @(posedge clk_i);
    chk(lane_six_link_status_o, 32'h0, "status in reset");
    rst_i <= 1'b0;
    t5 <= '{{8'h10, 8'h0f, 8'h10, 5'h15}, {8'hff, 8'h00, 8'h0f, 5'h1f}};
    t6 <= '{{8'h0f, 8'h10, 8'h0f, 5'h0a}, {8'h00, 8'hff, 8'hff, 5'h00}};
    wb(1'b1, 12'h304, 32'h10);
    rdchk(12'h4b5, 32'hb5, "lane five link 0");
    rdchk(12'h4b6, 32'h4a, "lane six link 0");
    wb(1'b1, 12'h300, 32'h1);
    chk(link_page_o, 32'h1, "page output");
    rdchk(12'h4b5, 32'h9f, "lane five link 1");
    chk(lane_five_link_status_o, 32'h9f, "lane five output");
    wb(1'b1, 12'h4b6, 32'hff);
    rdchk(12'h4b6, 32'h60, "lane six link 1");
    rdchk(12'h300, 32'h1, "page select");
    rdchk(12'h123, 32'h0, "unmapped data");
    chk(er, 1'b1, "unmapped err");
    rst_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    chk(lane_five_link_status_o, 32'h0, "status after reset");
    chk(link_page_o, 32'h0, "page after reset");
    rst_i <= 1'b0;
    rdchk(12'h4b6, 32'hea, "lane six threshold reset");
    give_verdict;
  end
  initial begin
    repeat (1000) @(posedge clk_i);
    err_count++;
    give_verdict;
  end
endmodule // tb_jlsr_regs
